// >>> src/jtb_tap.sv
`timescale 1ns/1ps
module jtb_tap (
  jtb_link_if.dev link,
  input wire logic [jtb_pkg::PINS-1:0] pad_in,
  input wire logic [jtb_pkg::PINS-1:0] core_out,
  output logic [jtb_pkg::PINS-1:0] pad_out,
  output logic ext_mode
);

  jtb_pkg::jtb_state_t state_reg;
  jtb_pkg::jtb_state_t state_next;
  logic [jtb_pkg::IR_W-1:0] ir_shift_reg;
  logic [jtb_pkg::IR_W-1:0] ir_reg;
  logic [jtb_pkg::ID_W-1:0] id_shift_reg;
  logic [jtb_pkg::BND_W-1:0] bnd_shift_reg;
  logic [jtb_pkg::BND_W-1:0] bnd_upd_reg;
  logic bypass_reg;
  logic [jtb_pkg::PINS-1:0] pad_meta_reg;
  logic [jtb_pkg::PINS-1:0] pad_sync_reg;
  logic [jtb_pkg::PINS-1:0] core_meta_reg;
  logic [jtb_pkg::PINS-1:0] core_sync_reg;
  logic [jtb_pkg::PINS-1:0] pad_out_reg;
  logic ext_mode_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic sel_bnd;
  logic sel_id;
  logic sel_ext;
  logic dr_out;

  // no ac mode: only these three instructions decode, any other code selects bypass
  assign sel_ext = (ir_reg == jtb_pkg::INS_EXTEST);
  assign sel_bnd = sel_ext || (ir_reg == jtb_pkg::INS_SAMPLE);
  assign sel_id = (ir_reg == jtb_pkg::INS_IDCODE);

  // state graph; tms of all ones leads to reset within five edges
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      jtb_pkg::JTB_TLR:
        state_next = link.tms ? jtb_pkg::JTB_TLR : jtb_pkg::JTB_RTI;
      jtb_pkg::JTB_RTI:
        state_next = link.tms ? jtb_pkg::JTB_SDR : jtb_pkg::JTB_RTI;
      jtb_pkg::JTB_SDR:
        state_next = link.tms ? jtb_pkg::JTB_SIR : jtb_pkg::JTB_CDR;
      jtb_pkg::JTB_CDR:
        state_next = link.tms ? jtb_pkg::JTB_E1DR : jtb_pkg::JTB_SHDR;
      jtb_pkg::JTB_SHDR:
        state_next = link.tms ? jtb_pkg::JTB_E1DR : jtb_pkg::JTB_SHDR;
      jtb_pkg::JTB_E1DR:
        state_next = link.tms ? jtb_pkg::JTB_UDR : jtb_pkg::JTB_PDR;
      jtb_pkg::JTB_PDR:
        state_next = link.tms ? jtb_pkg::JTB_E2DR : jtb_pkg::JTB_PDR;
      jtb_pkg::JTB_E2DR:
        state_next = link.tms ? jtb_pkg::JTB_UDR : jtb_pkg::JTB_SHDR;
      jtb_pkg::JTB_UDR:
        state_next = link.tms ? jtb_pkg::JTB_SDR : jtb_pkg::JTB_RTI;
      jtb_pkg::JTB_SIR:
        state_next = link.tms ? jtb_pkg::JTB_TLR : jtb_pkg::JTB_CIR;
      jtb_pkg::JTB_CIR:
        state_next = link.tms ? jtb_pkg::JTB_E1IR : jtb_pkg::JTB_SHIR;
      jtb_pkg::JTB_SHIR:
        state_next = link.tms ? jtb_pkg::JTB_E1IR : jtb_pkg::JTB_SHIR;
      jtb_pkg::JTB_E1IR:
        state_next = link.tms ? jtb_pkg::JTB_UIR : jtb_pkg::JTB_PIR;
      jtb_pkg::JTB_PIR:
        state_next = link.tms ? jtb_pkg::JTB_E2IR : jtb_pkg::JTB_PIR;
      jtb_pkg::JTB_E2IR:
        state_next = link.tms ? jtb_pkg::JTB_UIR : jtb_pkg::JTB_SHIR;
      jtb_pkg::JTB_UIR:
        state_next = link.tms ? jtb_pkg::JTB_SDR : jtb_pkg::JTB_RTI;
      default:
        state_next = jtb_pkg::JTB_TLR;
    endcase
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      state_reg <= jtb_pkg::JTB_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction shift path
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_shift_reg <= jtb_pkg::IR_CAPTURE;
    end else if (state_reg == jtb_pkg::JTB_CIR) begin
      ir_shift_reg <= jtb_pkg::IR_CAPTURE;
    end else if (state_reg == jtb_pkg::JTB_SHIR) begin
      ir_shift_reg <= {link.tdi, ir_shift_reg[jtb_pkg::IR_W-1:1]};
    end
  end

  // current instruction changes only in update-ir, or returns to idcode in test-logic-reset
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_reg <= jtb_pkg::INS_IDCODE;
    end else if (state_reg == jtb_pkg::JTB_TLR) begin
      ir_reg <= jtb_pkg::INS_IDCODE;
    end else if (state_reg == jtb_pkg::JTB_UIR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  // pad and core levels cross into tck domain
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
      core_meta_reg <= '0;
      core_sync_reg <= '0;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
      core_meta_reg <= core_out;
      core_sync_reg <= core_meta_reg;
    end
  end

  // parallel data registers, tdi to the selected one
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bypass_reg <= 1'b0;
      id_shift_reg <= '0;
      bnd_shift_reg <= '0;
    end else if (state_reg == jtb_pkg::JTB_CDR) begin
      bypass_reg <= 1'b0;
      id_shift_reg <= jtb_pkg::ID_CODE;
      bnd_shift_reg <= {core_sync_reg, pad_sync_reg};
    end else if (state_reg == jtb_pkg::JTB_SHDR) begin
      if (sel_bnd) begin
        bnd_shift_reg <= {link.tdi, bnd_shift_reg[jtb_pkg::BND_W-1:1]};
      end else if (sel_id) begin
        id_shift_reg <= {link.tdi, id_shift_reg[jtb_pkg::ID_W-1:1]};
      end else begin
        bypass_reg <= link.tdi;
      end
    end
  end

  // boundary update latches on the falling edge
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bnd_upd_reg <= '0;
    end else if (state_reg == jtb_pkg::JTB_UDR && sel_bnd) begin
      bnd_upd_reg <= bnd_shift_reg;
    end
  end

  // pins follow the update latches while extest is current
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      pad_out_reg <= '0;
      ext_mode_reg <= 1'b0;
    end else begin
      ext_mode_reg <= sel_ext;
      pad_out_reg <= sel_ext ? bnd_upd_reg[jtb_pkg::BND_W-1:jtb_pkg::PINS]
                             : core_sync_reg;
    end
  end

  always_comb begin
    if (sel_bnd) begin
      dr_out = bnd_shift_reg[0];
    end else if (sel_id) begin
      dr_out = id_shift_reg[0];
    end else begin
      dr_out = bypass_reg;
    end
  end

  // serial output launched on falling edge, enabled only in shift
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_oe_reg <= (state_reg == jtb_pkg::JTB_SHDR) ||
                    (state_reg == jtb_pkg::JTB_SHIR);
      tdo_reg <= (state_reg == jtb_pkg::JTB_SHIR) ? ir_shift_reg[0]
                                                  : dr_out;
    end
  end

  assign link.tdo = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;
  assign pad_out = pad_out_reg;
  assign ext_mode = ext_mode_reg;

endmodule // jtb_tap

// >>> src/jtb_pkg.sv
package jtb_pkg;

  // tap controller states
  typedef enum logic [3:0] {
    JTB_TLR  = 4'hF,
    JTB_RTI  = 4'hC,
    JTB_SDR  = 4'h7,
    JTB_CDR  = 4'h6,
    JTB_SHDR = 4'h2,
    JTB_E1DR = 4'h1,
    JTB_PDR  = 4'h3,
    JTB_E2DR = 4'h0,
    JTB_UDR  = 4'h5,
    JTB_SIR  = 4'h4,
    JTB_CIR  = 4'hE,
    JTB_SHIR = 4'hA,
    JTB_E1IR = 4'h9,
    JTB_PIR  = 4'hB,
    JTB_E2IR = 4'h8,
    JTB_UIR  = 4'hD
  } jtb_state_t;

  localparam int IR_W = 6;
  localparam int ID_W = 32;
  localparam int PINS = 4;
  localparam int BND_W = 2 * PINS;
  localparam int LEN_W = 6;

  localparam logic [IR_W-1:0] INS_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] INS_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] INS_IDCODE = 6'h02;
  localparam logic [IR_W-1:0] INS_BYPASS = 6'h3F;
  localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;

  // identity value is arbitrary; bit 0 set as the scan convention asks
  localparam logic [ID_W-1:0] ID_CODE = 32'h0A5C_3001;

  // tms=1 edges needed to reach test-logic-reset
  localparam int RESET_ONES = 5;

  // host divider: half period of tck in clk cycles
  localparam int CLK_NS = 8;
  localparam int TCK_NS = 64;
  localparam int TCK_HALF = TCK_NS / (2 * CLK_NS);

  // tms lead-in from run-test/idle to the shift state
  localparam int HEAD_DR = 3;
  localparam int HEAD_IR = 4;
  localparam logic [3:0] HEAD_DR_TMS = 4'h1;
  localparam logic [3:0] HEAD_IR_TMS = 4'h3;
  localparam int TAIL_LEN = 2;

endpackage

// >>> src/jtb_link_if.sv
`timescale 1ns/1ps
interface jtb_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe;

  modport dev (
    input tck,
    input tms,
    input tdi,
    input trst_n,
    output tdo,
    output tdo_oe
  );

  modport tst (
    output tck,
    output tms,
    output tdi,
    output trst_n,
    input tdo,
    input tdo_oe
  );
endinterface

// >>> src/jtb_tester.sv
`timescale 1ns/1ps
module jtb_tester (
  input wire logic clk,
  input wire logic rst,
  jtb_link_if.tst link,
  input wire logic start,
  input wire logic is_ir,
  input wire logic [jtb_pkg::LEN_W-1:0] len,
  input wire logic [jtb_pkg::ID_W-1:0] din,
  output logic [jtb_pkg::ID_W-1:0] dout,
  output logic busy,
  output logic done
);

  logic [7:0] div_reg;
  logic tck_reg;
  logic tms_reg;
  logic tdi_reg;
  logic trst_n_reg;
  logic busy_reg;
  logic done_reg;
  logic init_reg;
  logic ir_reg;
  logic [7:0] step_reg;
  logic [7:0] total_reg;
  logic [7:0] head;
  logic [jtb_pkg::LEN_W-1:0] len_reg;
  logic [jtb_pkg::ID_W-1:0] din_reg;
  logic [jtb_pkg::ID_W-1:0] dout_reg;
  logic tdo_meta_reg;
  logic tdo_sync_reg;
  logic tick;
  logic rise;
  logic fall;
  logic tms_now;
  logic tdi_now;
  logic [7:0] sidx;
  logic [7:0] step_nx;

  assign tick = busy_reg && (div_reg == 8'(jtb_pkg::TCK_HALF - 1));
  assign rise = tick && !tck_reg;
  assign fall = tick && tck_reg;
  assign head = ir_reg ? 8'(jtb_pkg::HEAD_IR) : 8'(jtb_pkg::HEAD_DR);
  assign step_nx = step_reg + 8'h01;

  // tms/tdi for a given step of the current sequence
  function automatic logic [1:0] pins_at(input logic [7:0] s);
    logic [7:0] i;
    logic t;
    logic d;
    i = s - head;
    t = 1'b0;
    d = 1'b0;
    if (init_reg) begin
      t = (s < 8'(jtb_pkg::RESET_ONES));
    end else if (s < head) begin
      t = ir_reg ? jtb_pkg::HEAD_IR_TMS[s[1:0]]
                 : jtb_pkg::HEAD_DR_TMS[s[1:0]];
    end else if (i < 8'(len_reg)) begin
      t = (i == 8'(len_reg) - 8'h01);
      d = din_reg[i[4:0]];
    end else begin
      t = (i == 8'(len_reg));
    end
    return {t, d};
  endfunction

  // always_comb also follows the state that pins_at reads
  always_comb begin
    {tms_now, tdi_now} = pins_at(step_reg);
  end
  assign sidx = step_reg - head;

  // tdo crosses into clk domain
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo_meta_reg <= 1'b0;
      tdo_sync_reg <= 1'b0;
    end else begin
      tdo_meta_reg <= link.tdo;
      tdo_sync_reg <= tdo_meta_reg;
    end
  end

  // tck divider runs only while a sequence is in progress
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      tck_reg <= 1'b0;
    end else if (!busy_reg) begin
      div_reg <= 8'h00;
      tck_reg <= 1'b0;
    end else if (tick) begin
      div_reg <= 8'h00;
      tck_reg <= !tck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // sequencer: tms/tdi change at tck fall, tdo sampled at tck rise
  always_ff @(posedge clk) begin
    if (rst) begin
      trst_n_reg <= 1'b0;
      init_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      ir_reg <= 1'b0;
      step_reg <= 8'h00;
      total_reg <= 8'(jtb_pkg::RESET_ONES + 1);
      len_reg <= '0;
      din_reg <= '0;
      dout_reg <= '0;
      tms_reg <= 1'b1;
      tdi_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      trst_n_reg <= 1'b1;
      if (!busy_reg) begin
        if (init_reg && trst_n_reg) begin
          busy_reg <= 1'b1;
          step_reg <= 8'h00;
          tms_reg <= 1'b1;
        end else if (!init_reg && start && len != '0) begin
          busy_reg <= 1'b1;
          ir_reg <= is_ir;
          len_reg <= len;
          din_reg <= din;
          step_reg <= 8'h00;
          total_reg <= (is_ir ? 8'(jtb_pkg::HEAD_IR) : 8'(jtb_pkg::HEAD_DR))
                       + 8'(len) + 8'(jtb_pkg::TAIL_LEN);
          tms_reg <= 1'b1;
          tdi_reg <= 1'b0;
        end
      end else if (rise) begin
        step_reg <= step_nx;
        if (!init_reg && step_reg >= head && sidx < 8'(len_reg)) begin
          dout_reg[sidx[4:0]] <= tdo_sync_reg;
        end
      end else if (fall) begin
        if (step_reg == total_reg) begin
          busy_reg <= 1'b0;
          done_reg <= !init_reg;
          init_reg <= 1'b0;
          tms_reg <= 1'b0;
        end else begin
          tms_reg <= tms_now;
          tdi_reg <= tdi_now;
        end
      end
    end
  end

  assign link.tck = tck_reg;
  assign link.tms = tms_reg;
  assign link.tdi = tdi_reg;
  assign link.trst_n = trst_n_reg;
  assign dout = dout_reg;
  assign busy = busy_reg;
  assign done = done_reg;

endmodule // jtb_tester

// >>> tb/jtb_link_asserts.sv
`timescale 1ns/1ps
module jtb_link_asserts (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // next state per state code, tms low / tms high
  localparam logic [63:0] NXT0 = 64'hCACC_BABA_62CE_3232;
  localparam logic [63:0] NXT1 = 64'hF977_89DD_417F_0155;
  logic [3:0] st_reg;
  logic [5:0] irs_reg;
  logic [5:0] irc_reg;
  logic shd;
  logic shi;
  logic byp;
  logic bnd;
  assign shd = st_reg == jtb_pkg::JTB_SHDR;
  assign shi = st_reg == jtb_pkg::JTB_SHIR;
  assign byp = irc_reg == jtb_pkg::INS_BYPASS;
  assign bnd = irc_reg == jtb_pkg::INS_SAMPLE ||
               irc_reg == jtb_pkg::INS_EXTEST;
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st_reg <= jtb_pkg::JTB_TLR;
    end else begin
      st_reg <= tms ? NXT1[st_reg*4 +: 4] : NXT0[st_reg*4 +: 4];
    end
  end
  // current instruction as the device should hold it
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      irs_reg <= 6'h00;
      irc_reg <= jtb_pkg::INS_IDCODE;
    end else begin
      if (shi) irs_reg <= {tdi, irs_reg[5:1]};
      if (st_reg == jtb_pkg::JTB_UIR) irc_reg <= irs_reg;
      else if (st_reg == jtb_pkg::JTB_TLR) irc_reg <= jtb_pkg::INS_IDCODE;
    end
  end
  sequence s_cir_out;
    st_reg == jtb_pkg::JTB_CIR && !tms;
  endsequence
  sequence s_cdr_out;
    st_reg == jtb_pkg::JTB_CDR && !tms;
  endsequence
  a_oe_in_shift: assert property (
    @(posedge tck) disable iff (!trst_n) tdo_oe == (shd || shi))
    else $error("tdo enable outside shift");
  a_tdo_on_fall: assert property (
    @(tck) disable iff (!trst_n) tck |-> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo moved while tck high");
  a_five_ones: assert property (
    @(posedge tck) disable iff (!trst_n) tms [*5] |=> !tdo_oe)
    else $error("no reset after five ones");
  a_ir_capture: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_cir_out |=> tdo ##1 (!tdo || !shi))
    else $error("instruction capture wrong");
  a_id_first: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_cdr_out ##0 (irc_reg == jtb_pkg::INS_IDCODE) |=> tdo)
    else $error("identity bit 0 wrong");
  a_bypass_cap: assert property (
    @(posedge tck) disable iff (!trst_n) s_cdr_out ##0 byp |=> !tdo)
    else $error("bypass capture not 0");
  a_bypass_delay: assert property (
    @(posedge tck) disable iff (!trst_n)
    (shd && byp) ##1 shd |-> tdo == $past(tdi))
    else $error("bypass delay wrong");
  a_chain_len: assert property (
    @(posedge tck) disable iff (!trst_n)
    (shd && bnd) [*8] ##1 shd |-> tdo == $past(tdi, 8))
    else $error("boundary chain length wrong");
endmodule // jtb_link_asserts

// >>> tb/jtb_tap_boundary_scan_tb.sv
`timescale 1ns/1ps
module jtb_tap_boundary_scan_tb;
  logic clk;
  logic rst;
  logic start;
  logic is_ir;
  logic [5:0] len;
  logic [31:0] din;
  logic [31:0] dout;
  logic busy;
  logic done;
  logic [3:0] pad_in;
  logic [3:0] core_out;
  logic [3:0] pad_out;
  logic ext_mode;
  int err_total;
  int cmp_count;
  jtb_link_if link ();
  jtb_tap jtb_tap_inst (.link(link), .pad_in(pad_in),
    .core_out(core_out), .pad_out(pad_out), .ext_mode(ext_mode));
  jtb_tester jtb_tester_inst (.clk(clk), .rst(rst), .link(link),
    .start(start), .is_ir(is_ir), .len(len), .din(din), .dout(dout),
    .busy(busy), .done(done));
  jtb_link_asserts jtb_link_asserts_inst (.tck(link.tck), .tms(link.tms),
    .tdi(link.tdi), .trst_n(link.trst_n), .tdo(link.tdo),
    .tdo_oe(link.tdo_oe));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic scan(input logic ir, input logic [5:0] n,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    #1;
    start = 1'b1;
    is_ir = ir;
    len = n;
    din = d;
    @(posedge clk);
    #1;
    start = 1'b0;
    chk({31'h0, busy}, 32'h1);
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({30'h0, busy, k < 2000}, 32'h1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    start = 1'b0;
    is_ir = 1'b0;
    len = 6'h00;
    din = 32'h0;
    pad_in = 4'h9;
    core_out = 4'h6;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (80) @(posedge clk);
    scan(1'b0, 6'h20, 32'h0);
    chk(dout, jtb_pkg::ID_CODE);
    $display("test identity done");
    scan(1'b1, 6'h06, {26'h0, jtb_pkg::INS_BYPASS});
    chk({26'h0, dout[5:0]}, {26'h0, jtb_pkg::IR_CAPTURE});
    scan(1'b0, 6'h08, 32'hA5);
    chk({24'h0, dout[7:0]}, 32'h4A);
    scan(1'b0, 6'h01, 32'h1);
    chk({31'h0, dout[0]}, 32'h0);
    $display("test bypass done");
    // pins captured, chain preloaded with C in the drive cells
    scan(1'b1, 6'h06, {26'h0, jtb_pkg::INS_SAMPLE});
    scan(1'b0, 6'h10, 32'hC05A);
    chk({16'h0, dout[15:0]}, 32'h5A69);
    chk({27'h0, ext_mode, pad_out}, 32'h6);
    $display("test sample done");
    scan(1'b1, 6'h06, {26'h0, jtb_pkg::INS_EXTEST});
    chk({27'h0, ext_mode, pad_out}, 32'h1C);
    scan(1'b0, 6'h10, 32'h30A5);
    chk({16'h0, dout[15:0]}, 32'hA569);
    chk({27'h0, ext_mode, pad_out}, 32'h13);
    $display("test extest done");
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({25'h0, link.trst_n, link.tdo_oe, ext_mode, pad_out}, 32'h0);
    rst = 1'b0;
    repeat (80) @(posedge clk);
    scan(1'b0, 6'h20, 32'h0);
    chk(dout, jtb_pkg::ID_CODE);
    $display("test reset done");
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] t=%0t run did not complete", $time);
    end_of_test();
  end
endmodule // jtb_tap_boundary_scan_tb
